// >>> verilog/dsk_map.svh
// Constants for the decrement-and-skip execution block
`ifndef DSK_MAP_SVH
`define DSK_MAP_SVH
`define DSK_DEST_WREG      1'b0
`define DSK_DEST_FILE      1'b1
`define DSK_ACCESS_BANK    1'b0
`define DSK_BANKED         1'b1
`define DSK_ILO_LIMIT      8'h5F
`define DSK_ACCESS_SPLIT   8'h80
`define DSK_ACCESS_HI_BANK 4'hF
`define DSK_CLK_NS         8
`define DSK_QPHASES        3'd4
`define DSK_OPC_ZERO       6'b0010_11
`define DSK_OPC_NONZERO    6'b0100_11
`endif

// >>> verilog/dsk_pkg.sv
// Types for the decrement-and-skip execution block
package dsk_pkg;
  typedef enum logic [1:0] {
    DSK_Q1,
    DSK_Q2,
    DSK_Q3,
    DSK_Q4
  } dsk_phase_t;

  typedef enum logic [1:0] {
    DSK_RUN,
    DSK_FLUSH1,
    DSK_FLUSH2
  } dsk_mode_t;

  typedef struct packed {
    logic [15:0] word;
    logic        valid;
    logic        next_two_word;
  } dsk_fetch_t;

  typedef struct packed {
    logic        we;
    logic [11:0] addr;
    logic [7:0]  data;
  } dsk_file_wr_t;
endpackage

// >>> verilog/dsk_addr_gen.sv
// Operand address generation for byte-oriented instructions
`timescale 1ns/100ps
`include "dsk_map.svh"
module dsk_addr_gen
  import dsk_pkg::*;
(
  input  wire logic [7:0]  f_field,    // Operand field
  input  wire logic        a_bit,      // Access-bank select bit
  input  wire logic [3:0]  bank_select_register, // Bank select
  input  wire logic        ext_en,     // Extended set enabled
  input  wire logic [11:0] index_base, // Index base for literal offset
  output logic      [11:0] addr        // Effective address
);
  always_comb
  begin
    if (a_bit == `DSK_BANKED)
      addr = {bank_select_register, f_field};
    else if (ext_en && f_field <= `DSK_ILO_LIMIT)
      addr = 12'(index_base + {4'h0, f_field});
    else if (f_field < `DSK_ACCESS_SPLIT)
      addr = {4'h0, f_field};
    else
      addr = {`DSK_ACCESS_HI_BANK, f_field};
  end
endmodule // dsk_addr_gen

// >>> verilog/dsk_exec.sv
// Decrement-and-skip execution unit with four-phase cycle sequencing
//------------------------------------------------------------
// Functional notes
//------------------------------------------------------------
`timescale 1ns/100ps
`include "dsk_map.svh"
module dsk_exec
  import dsk_pkg::*;
(
  input  wire logic        ref_clk,    // Core clock
  input  wire logic        reset,      // Sync reset, active high
  input  wire dsk_fetch_t  fetch,      // Prefetched instruction
  input  wire logic [3:0]  bank_select_register, // Bank select
  input  wire logic        ext_en,     // Extended set enabled
  input  wire logic [11:0] index_base, // Literal-offset base
  input  wire logic [7:0]  file_rdata, // Operand read data
  output logic      [11:0] file_raddr, // Operand read address
  output dsk_file_wr_t     file_wr,    // File write port
  output logic      [7:0]  wreg,       // Working register
  output logic             wreg_we,    // Working register written
  output logic             skip_nop,   // Executing a discarded slot
  output dsk_phase_t       phase,      // Current Q phase
  output logic             cycle_end   // Last phase of a cycle
);
  //------------------------------------------------------------
  // Decode
  //------------------------------------------------------------
  logic [15:0]  ir;
  logic [15:0]  next_ir;
  logic         ir_valid;
  logic         next_ir_valid;
  dsk_mode_t    mode;
  dsk_mode_t    next_mode;
  dsk_phase_t   next_phase;
  logic [7:0]   operand;
  logic [7:0]   next_operand;
  logic [7:0]   result;
  logic [7:0]   next_result;
  logic [7:0]   next_wreg;
  logic         next_wreg_we;
  logic         next_skip_nop;
  logic         next_cycle_end;
  logic [11:0]  eff_addr;
  logic [11:0]  next_file_raddr;
  dsk_file_wr_t next_file_wr;
  logic         is_zero_op;
  logic         is_nonzero_op;
  logic         skip_taken;

  assign is_zero_op    = ir_valid && ir[15:10] == `DSK_OPC_ZERO;
  assign is_nonzero_op = ir_valid && ir[15:10] == `DSK_OPC_NONZERO;
  // Neither variant touches any flag: no status path exists here
  assign skip_taken = (is_zero_op && result == 8'h00) ||
                      (is_nonzero_op && result != 8'h00);

  dsk_addr_gen u_addr
  (
    .f_field              (ir[7:0]),
    .a_bit                (ir[8]),
    .bank_select_register (bank_select_register),
    .ext_en               (ext_en),
    .index_base           (index_base),
    .addr                 (eff_addr)
  );

  //------------------------------------------------------------
  // Sequencing
  //------------------------------------------------------------
  always_comb
  begin
    next_phase      = phase;
    next_mode       = mode;
    next_ir         = ir;
    next_ir_valid   = ir_valid;
    next_operand    = operand;
    next_result     = result;
    next_wreg       = wreg;
    next_wreg_we    = 1'b0;
    next_skip_nop   = skip_nop;
    next_file_raddr = file_raddr;
    next_file_wr    = '{we: 1'b0, addr: file_wr.addr, data: file_wr.data};
    next_cycle_end  = 1'b0;
    case (phase)
      DSK_Q1:
      begin
        next_phase = DSK_Q2;
        if (mode == DSK_RUN)
          next_file_raddr = eff_addr;
      end
      DSK_Q2:
      begin
        next_phase = DSK_Q3;
        if (mode == DSK_RUN)
          next_operand = file_rdata;
      end
      DSK_Q3:
      begin
        next_phase = DSK_Q4;
        next_cycle_end = 1'b1;
        if (mode == DSK_RUN)
          next_result = operand - 8'h01;
      end
      DSK_Q4:
      begin
        next_phase = DSK_Q1;
        if (mode == DSK_RUN && (is_zero_op || is_nonzero_op))
        begin
          if (ir[9] == `DSK_DEST_WREG)
          begin
            next_wreg    = result;
            next_wreg_we = 1'b1;
          end
          else
            next_file_wr = '{we: 1'b1, addr: file_raddr, data: result};
        end
        if (mode == DSK_RUN && skip_taken)
        begin
          // Fetched word is squashed, never decoded
          next_ir_valid = 1'b0;
          next_skip_nop = 1'b1;
          next_mode = fetch.next_two_word ? DSK_FLUSH2 : DSK_FLUSH1;
        end
        else if (mode == DSK_FLUSH2)
        begin
          next_mode = DSK_FLUSH1;
          next_ir_valid = 1'b0;
        end
        else
        begin
          next_mode     = DSK_RUN;
          next_skip_nop = 1'b0;
          next_ir       = fetch.word;
          next_ir_valid = fetch.valid;
        end
      end
      default:
        next_phase = DSK_Q1;
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      phase      <= DSK_Q1;
      mode       <= DSK_RUN;
      ir         <= 16'h0000;
      ir_valid   <= 1'b0;
      operand    <= 8'h00;
      result     <= 8'h00;
      wreg       <= 8'h00;
      wreg_we    <= 1'b0;
      skip_nop   <= 1'b0;
      file_raddr <= 12'h000;
      file_wr    <= '0;
      cycle_end  <= 1'b0;
    end
    else
    begin
      phase      <= next_phase;
      mode       <= next_mode;
      ir         <= next_ir;
      ir_valid   <= next_ir_valid;
      operand    <= next_operand;
      result     <= next_result;
      wreg       <= next_wreg;
      wreg_we    <= next_wreg_we;
      skip_nop   <= next_skip_nop;
      file_raddr <= next_file_raddr;
      file_wr    <= next_file_wr;
      cycle_end  <= next_cycle_end;
    end
  end

  //------------------------------------------------------------
  // Assertions
  //------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  a_write_in_q4: assert property (file_wr.we |-> phase == DSK_Q1)
    else $error("File write outside Q4 boundary");
  a_dest_wreg_sel: assert property (
    phase == DSK_Q4 && mode == DSK_RUN && (is_zero_op || is_nonzero_op)
    && ir[9] == 1'b0 |=> wreg_we && wreg == $past(result))
    else $error("Working register not loaded");
  a_dest_file_sel: assert property (
    phase == DSK_Q4 && mode == DSK_RUN && (is_zero_op || is_nonzero_op)
    && ir[9] == 1'b1 |=> file_wr.we && !wreg_we)
    else $error("File not written back");
  a_decrement_val: assert property (
    phase == DSK_Q3 && mode == DSK_RUN |=> result == $past(operand) - 8'h01)
    else $error("Decrement wrong");
  a_skip_nop: assert property (
    phase == DSK_Q4 && mode == DSK_RUN && skip_taken
    |=> skip_nop && !ir_valid)
    else $error("Skip did not squash");
  a_skip_cond: assert property (
    phase == DSK_Q4 && is_zero_op && mode == DSK_RUN && result != 8'h00
    |=> mode == DSK_RUN)
    else $error("Zero form skipped on non-zero");
  a_two_word_skip: assert property (
    phase == DSK_Q4 && mode == DSK_RUN && skip_taken && fetch.next_two_word
    |=> mode == DSK_FLUSH2 ##4 mode == DSK_FLUSH1)
    else $error("Two-word skip not three cycles");
  a_phase_order: assert property (
    phase == DSK_Q1 |=> phase == DSK_Q2 ##1 phase == DSK_Q3
    ##1 phase == DSK_Q4)
    else $error("Phase order broken");
  a_bank_addr: assert property (
    phase == DSK_Q1 && mode == DSK_RUN && ir[8]
    |=> file_raddr[11:8] == $past(bank_select_register))
    else $error("Banked address wrong");
  a_ilo_addr: assert property (
    phase == DSK_Q1 && mode == DSK_RUN && !ir[8] && ext_en
    && ir[7:0] <= 8'h5F
    |=> file_raddr == $past(index_base) + {4'h0, $past(ir[7:0])})
    else $error("Literal offset address wrong");

  c_zero_skip:   cover property (phase == DSK_Q4 && is_zero_op && skip_taken);
  c_nz_skip:     cover property (
    phase == DSK_Q4 && is_nonzero_op && skip_taken);
  c_two_word:    cover property (mode == DSK_FLUSH2);
  c_wreg_dest:   cover property (wreg_we);
endmodule // dsk_exec

// >>> testbench/decrement_skip_execution_tb.sv
// Self-checking testbench for the decrement-and-skip execution unit
`timescale 1ns/100ps
module decrement_skip_execution_tb;
  import dsk_pkg::*;

  //------------------------------------------------------------
  // Signals
  //------------------------------------------------------------
  logic         ref_clk;
  logic         reset;
  dsk_fetch_t   fetch;
  logic [3:0]   bank_select_register;
  logic         ext_en;
  logic [11:0]  index_base;
  logic [7:0]   file_rdata;
  logic [11:0]  file_raddr;
  dsk_file_wr_t file_wr;
  logic [7:0]   wreg;
  logic         wreg_we;
  logic         skip_nop;
  dsk_phase_t   phase;
  logic         cycle_end;
  logic [11:0]  rd_addr;
  logic [7:0]   opnd_val;
  int           errors;
  int           samples_checked;

  // Wrong address reads the inverse, so a bad address shows in the result
  assign file_rdata = (file_raddr == rd_addr) ? opnd_val : ~opnd_val;

  dsk_exec dsk_exec_inst (
    .ref_clk              (ref_clk),
    .reset                (reset),
    .fetch                (fetch),
    .bank_select_register (bank_select_register),
    .ext_en               (ext_en),
    .index_base           (index_base),
    .file_rdata           (file_rdata),
    .file_raddr           (file_raddr),
    .file_wr              (file_wr),
    .wreg                 (wreg),
    .wreg_we              (wreg_we),
    .skip_nop             (skip_nop),
    .phase                (phase),
    .cycle_end            (cycle_end)
  );

  always #4 ref_clk = ~ref_clk;

  //------------------------------------------------------------
  // Shared tasks
  //------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish();
    if (errors == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // Runs one instruction from a fresh reset; a writing filler follows it
  // so that a discarded slot that still executed would be seen
  task automatic run_op(input logic [15:0] w, input logic two,
                        input logic [3:0] bank, input logic ext,
                        input logic [11:0] ea, input logic [7:0] opnd);
    logic [7:0] res;
    logic       known;
    logic       skip;
    int         sk;
    int         wr;
    logic [31:0] exp_sk;
    res   = opnd - 8'h01;
    known = (w[15:10] == 6'b0010_11) || (w[15:10] == 6'b0100_11);
    skip  = known && ((w[15:10] == 6'b0010_11) == (res == 8'h00));
    sk    = 0;
    wr    = 0;
    bank_select_register = bank;
    ext_en   = ext;
    rd_addr  = ea;
    opnd_val = opnd;
    reset    = 1'b1;
    repeat (5) @(negedge ref_clk);
    reset = 1'b0;
    while (phase !== DSK_Q4) @(negedge ref_clk);
    fetch = '{word: w, valid: 1'b1, next_two_word: 1'b0};
    for (int c = 0; c < 16; c++)
    begin
      @(negedge ref_clk);
      if (c == 0)
        fetch = '{word: 16'h2C00, valid: 1'b1, next_two_word: two};
      if (c < 4)
      begin
        check({30'h0000_0000, phase}, 32'(c));
        check({31'h0000_0000, cycle_end}, {31'h0, c == 3});
      end
      if (c == 2 && known)
        check({20'h0_0000, file_raddr}, {20'h0_0000, ea});
      if (c == 4)
      begin
        check({31'h0, wreg_we}, {31'h0, known && !w[9]});
        check({31'h0, file_wr.we}, {31'h0, known && w[9]});
        if (known && !w[9])
          check({24'h00_0000, wreg}, {24'h00_0000, res});
        if (known && w[9])
          check({12'h000, file_wr.addr, file_wr.data},
                {12'h000, ea, res});
        check({31'h0, skip_nop}, {31'h0, skip});
      end
      if (c >= 4 && skip_nop === 1'b1)
        sk++;
      if (c >= 5 && c <= 11 && (wreg_we === 1'b1 || file_wr.we === 1'b1))
        wr++;
    end
    exp_sk = skip ? (two ? 32'h0000_0008 : 32'h0000_0004) : 32'h0;
    check(32'(sk), exp_sk);
    // An unknown word is not a skip, so the filler after it still runs
    check(32'(wr), skip ? 32'h0 : 32'h0000_0001);
  endtask

  //------------------------------------------------------------
  // Main sequence and watchdog
  //------------------------------------------------------------
  initial
  begin
    ref_clk  = 1'b0;
    reset    = 1'b1;
    fetch    = '{word: 16'h0000, valid: 1'b0, next_two_word: 1'b0};
    bank_select_register = 4'h0;
    ext_en   = 1'b0;
    index_base = 12'h300;
    rd_addr  = 12'h000;
    opnd_val = 8'h00;
    errors   = 0;
    samples_checked = 0;
    run_op(16'h2F34, 1'b0, 4'h2, 1'b0, 12'h234, 8'h05);
    run_op(16'h2C90, 1'b0, 4'h2, 1'b0, 12'hF90, 8'h01);
    run_op(16'h2E5F, 1'b1, 4'h5, 1'b1, 12'h35F, 8'h01);
    run_op(16'h4C60, 1'b0, 4'h5, 1'b1, 12'h060, 8'h01);
    run_op(16'h4F00, 1'b1, 4'hA, 1'b1, 12'hA00, 8'h00);
    run_op(16'h4C7F, 1'b0, 4'hA, 1'b0, 12'h07F, 8'h80);
    run_op(16'h1C7F, 1'b0, 4'h0, 1'b0, 12'h07F, 8'h01);
    tally_and_finish();
  end

  // About 200 cycles expected; ten times that means a hang
  initial
  begin
    #16000;
    errors++;
    tally_and_finish();
  end
endmodule // decrement_skip_execution_tb
